// *** hdl/pie_pkg.sv ***
// Purpose: Shared constants and types for the interrupt/exception controller
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   Level 0 is the most urgent priority level
package pie_pkg;
  localparam int MAX_SRC = 56;
  localparam int NUM_EXT = 7;
  localparam int EXT_BASE = 1;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_MASK_LO = 12'h000;
  localparam logic [11:0] OFF_MASK_HI = 12'h004;
  localparam logic [11:0] OFF_PEND_LO = 12'h008;
  localparam logic [11:0] OFF_PEND_HI = 12'h00c;
  localparam logic [11:0] OFF_THRESH  = 12'h010;
  localparam logic [11:0] OFF_EXT_CFG = 12'h014;
  localparam logic [11:0] OFF_ISTAT   = 12'h018;
  localparam logic [11:0] OFF_IMASK   = 12'h01c;
  localparam logic [11:0] OFF_LAST    = 12'h020;
  localparam logic [6:0]  OFF_PRIO_PG = 7'h02;
  localparam logic [2:0]  PRIO_WORDS  = 3'h7;
  // ----------------------------------------
  // Reset values, codes, counts
  // ----------------------------------------
  localparam logic [MAX_SRC-1:0] MASK_RST = '1;
  localparam logic [2:0]  PRIO_RST   = 3'h7;
  localparam logic [3:0]  THRESH_RST = 4'h8;
  localparam logic [1:0]  FILT_SAMPLES = 2'h3;
  localparam logic [15:0] CODE_TRAP_LO = 16'h0040;
  localparam logic [15:0] CODE_TRAP_HI = 16'h0050;
  localparam logic [15:0] CODE_ILL     = 16'h0060;
  localparam logic [15:0] CODE_MASK    = 16'h0080;
  localparam logic [31:0] VEC_TRAP_LO  = 32'h00000040;
  localparam logic [31:0] VEC_TRAP_HI  = 32'h00000050;
  localparam logic [31:0] VEC_ILL      = 32'h00000060;
  localparam int IST_TAKEN = 0;
  localparam int IST_ILL   = 1;
  localparam int IST_TRAP  = 2;

  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_OFF} pie_edge_t;
  typedef enum logic {PH_IDLE, PH_SHOW} pie_phase_t;
  typedef enum logic [1:0] {K_MASK, K_TRAP, K_ILL} pie_kind_t;

  typedef struct packed {
    logic [MAX_SRC-1:0]        mask;
    logic [MAX_SRC-1:0]        pend;
    logic [MAX_SRC-1:0][2:0]   prio;
    logic [3:0]                thresh;
    logic [NUM_EXT-1:0][2:0]   ext_cfg;
    logic [NUM_EXT-1:0][1:0]   filt_cnt;
    logic [NUM_EXT-1:0]        filt_lvl;
    logic [2:0]                istat;
    logic [2:0]                imask;
    logic                      trap_pend;
    logic [4:0]                trap_num;
    logic                      ill_pend;
    pie_phase_t                phase;
    pie_kind_t                 kind;
    logic [5:0]                src;
    logic                      valid;
    logic [15:0]               code;
    logic [31:0]               handler;
    logic                      irq;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } pie_state_t;

  localparam pie_state_t PIE_ST_RST = '{mask: MASK_RST, prio: {MAX_SRC{PRIO_RST}},
                                        thresh: THRESH_RST, phase: PH_IDLE,
                                        kind: K_MASK, default: '0};
endpackage : pie_pkg

// *** hdl/pie_ctrl.sv ***
// Purpose: Vectored request controller with traps and illegal-opcode trap
// Assumes: Request, trap and pin inputs synchronous to pclk
// Notes:   Presented exception holds until exc_ack
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
// Operation
// - Software gives each maskable source one of eight levels; arbitration uses them.
// - Requests whose level is not above the permitted threshold are held off.
// - Each maskable source has a mask bit; masked sources are not forwarded.
// - External pins get optional noise filter, edge detect and chosen edge.
// - Accepts peripheral and pin requests, 49 to 56 sources by variant.
// - Trap low group gives code 004n, high group 005n with vector 50h.
// - Undefined opcode fetch gives code 0060h and vector 60h.
module pie_ctrl
  import pie_pkg::*;
#(
  parameter int NUM_SRC = 56
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [31:0]             prdata,
  input  wire logic [NUM_SRC-1:0] src_req,
  input  wire logic [NUM_EXT-1:0] ext_pin,
  input  wire logic               trap_req,
  input  wire logic [4:0]         trap_num,
  input  wire logic               undefined_opcode_trap,
  output logic                    exc_valid,
  output logic [15:0]             exc_code,
  output logic [31:0]             exc_handler,
  input  wire logic               exc_ack,
  output logic                    irq
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[11:5] == 7'h00) ||
              (a == OFF_LAST) ||
              (a[11:5] == OFF_PRIO_PG && a[4:2] != PRIO_WORDS);
  endfunction : addr_ok

  function automatic logic [15:0] mask_code(input logic [5:0] s);
    mask_code = CODE_MASK + {6'h00, s, 4'h0};
  endfunction : mask_code

  pie_state_t st_ff;
  pie_state_t nxt_st;

  logic [MAX_SRC-1:0] valid_src;
  logic [MAX_SRC-1:0] set_v;
  logic [MAX_SRC-1:0] clr_w;
  logic [MAX_SRC-1:0] clr_a;
  logic [NUM_EXT-1:0] ext_evt;
  logic               found;
  logic [2:0]         blvl;
  logic [5:0]         bsrc;
  logic               wr_en;
  logic               rd_clr;
  logic [31:0]        rd_v;
  logic [2:0]         pw;
  logic               cur;
  pie_edge_t          esel;

  always_comb begin
    valid_src = '0;
    valid_src[NUM_SRC-1:0] = '1;
  end

  // ----------------------------------------
  // Pin conditioning
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    ext_evt = '0;
    cur = 1'b0;
    esel = EDGE_OFF;
    for (int k = 0; k < NUM_EXT; k++) begin
      cur = ext_pin[k];
      nxt_st.filt_cnt[k] = 2'h0;
      if (st_ff.ext_cfg[k][0]) begin
        // Glitches shorter than the count never reach the edge detector
        if (ext_pin[k] == st_ff.filt_lvl[k]) begin
          cur = st_ff.filt_lvl[k];
        end else if (st_ff.filt_cnt[k] == FILT_SAMPLES - 2'h1) begin
          cur = ext_pin[k];
        end else begin
          cur = st_ff.filt_lvl[k];
          nxt_st.filt_cnt[k] = st_ff.filt_cnt[k] + 2'h1;
        end
      end
      nxt_st.filt_lvl[k] = cur;
      esel = pie_edge_t'(st_ff.ext_cfg[k][2:1]);
      ext_evt[k] = (cur & ~st_ff.filt_lvl[k] &
                    (esel == EDGE_RISE || esel == EDGE_BOTH)) |
                   (~cur & st_ff.filt_lvl[k] &
                    (esel == EDGE_FALL || esel == EDGE_BOTH));
    end

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    found = 1'b0;
    blvl = PRIO_RST;
    bsrc = 6'h00;
    for (int i = 0; i < MAX_SRC; i++) begin
      if (valid_src[i] && st_ff.pend[i] && !st_ff.mask[i] &&
          {1'b0, st_ff.prio[i]} < st_ff.thresh &&
          (!found || st_ff.prio[i] < blvl)) begin
        found = 1'b1;
        blvl = st_ff.prio[i];
        bsrc = 6'(i);
      end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    wr_en = psel && penable && st_ff.pready && pwrite && addr_ok(paddr);
    rd_clr = psel && penable && st_ff.pready && !pwrite && paddr == OFF_ISTAT;
    pw = paddr[4:2];
    rd_v = 32'h00000000;
    case (paddr)
      OFF_MASK_LO: rd_v = st_ff.mask[31:0];
      OFF_MASK_HI: rd_v = {8'h00, st_ff.mask[MAX_SRC-1:32]};
      OFF_PEND_LO: rd_v = st_ff.pend[31:0];
      OFF_PEND_HI: rd_v = {8'h00, st_ff.pend[MAX_SRC-1:32]};
      OFF_THRESH:  rd_v = {28'h0000000, st_ff.thresh};
      OFF_EXT_CFG: begin
        for (int k = 0; k < NUM_EXT; k++) begin
          rd_v[4*k +: 3] = st_ff.ext_cfg[k];
        end
      end
      OFF_ISTAT:   rd_v = {29'h00000000, st_ff.istat};
      OFF_IMASK:   rd_v = {29'h00000000, st_ff.imask};
      OFF_LAST:    rd_v = {st_ff.valid, 9'h000, st_ff.src, st_ff.code};
      default: begin
        if (paddr[11:5] == OFF_PRIO_PG) begin
          for (int j = 0; j < 8; j++) begin
            if (int'(pw) * 8 + j < MAX_SRC) begin
              rd_v[4*j +: 3] = st_ff.prio[int'(pw) * 8 + j];
            end
          end
        end
      end
    endcase
    // Answer in the first access cycle; data latched at setup
    nxt_st.pready = psel && !penable;
    nxt_st.pslverr = psel && !penable && !addr_ok(paddr);
    nxt_st.prdata = (psel && !penable && !pwrite) ? rd_v : 32'h00000000;

    clr_w = '0;
    if (wr_en) begin
      case (paddr)
        OFF_MASK_LO: nxt_st.mask[31:0] = pwdata;
        OFF_MASK_HI: nxt_st.mask[MAX_SRC-1:32] = pwdata[23:0];
        OFF_PEND_LO: clr_w[31:0] = pwdata;
        OFF_PEND_HI: clr_w[MAX_SRC-1:32] = pwdata[23:0];
        OFF_THRESH:  nxt_st.thresh = pwdata[3:0];
        OFF_EXT_CFG: begin
          for (int k = 0; k < NUM_EXT; k++) begin
            nxt_st.ext_cfg[k] = pwdata[4*k +: 3];
          end
        end
        OFF_IMASK:   nxt_st.imask = pwdata[2:0];
        default: begin
          if (paddr[11:5] == OFF_PRIO_PG) begin
            for (int j = 0; j < 8; j++) begin
              if (int'(pw) * 8 + j < MAX_SRC) begin
                nxt_st.prio[int'(pw) * 8 + j] = pwdata[4*j +: 3];
              end
            end
          end
        end
      endcase
    end

    // ----------------------------------------
    // Presentation to the core
    // ----------------------------------------
    clr_a = '0;
    if (rd_clr) begin
      // Only bits already returned are cleared, so a late event is kept
      nxt_st.istat = st_ff.istat & ~st_ff.prdata[2:0];
    end
    case (st_ff.phase)
      PH_IDLE: begin
        // Program-driven exceptions outrank interrupts
        if (st_ff.ill_pend) begin
          nxt_st.phase = PH_SHOW;
          nxt_st.valid = 1'b1;
          nxt_st.kind = K_ILL;
          nxt_st.code = CODE_ILL;
          nxt_st.handler = VEC_ILL;
        end else if (st_ff.trap_pend) begin
          nxt_st.phase = PH_SHOW;
          nxt_st.valid = 1'b1;
          nxt_st.kind = K_TRAP;
          if (st_ff.trap_num[4]) begin
            nxt_st.code = CODE_TRAP_HI | {12'h000, st_ff.trap_num[3:0]};
            nxt_st.handler = VEC_TRAP_HI;
          end else begin
            nxt_st.code = CODE_TRAP_LO | {12'h000, st_ff.trap_num[3:0]};
            nxt_st.handler = VEC_TRAP_LO;
          end
        end else if (found) begin
          nxt_st.phase = PH_SHOW;
          nxt_st.valid = 1'b1;
          nxt_st.kind = K_MASK;
          nxt_st.src = bsrc;
          nxt_st.code = mask_code(bsrc);
          nxt_st.handler = {16'h0000, mask_code(bsrc)};
        end
      end
      PH_SHOW: begin
        if (exc_ack) begin
          nxt_st.phase = PH_IDLE;
          nxt_st.valid = 1'b0;
          nxt_st.istat[IST_TAKEN] = 1'b1;
          case (st_ff.kind)
            K_ILL:  nxt_st.ill_pend = 1'b0;
            K_TRAP: nxt_st.trap_pend = 1'b0;
            default: begin
              clr_a[st_ff.src] = 1'b1;
              // Holds off equal and lower levels until software restores
              nxt_st.thresh = {1'b0, st_ff.prio[st_ff.src]};
            end
          endcase
        end
      end
      default: begin
        nxt_st.phase = PH_IDLE;
        nxt_st.valid = 1'b0;
      end
    endcase

    // New events win over any clear in the same cycle
    set_v = '0;
    set_v[NUM_SRC-1:0] = src_req;
    for (int k = 0; k < NUM_EXT; k++) begin
      set_v[EXT_BASE + k] = set_v[EXT_BASE + k] | ext_evt[k];
    end
    nxt_st.pend = ((st_ff.pend & ~clr_w & ~clr_a) | set_v) & valid_src;
    if (undefined_opcode_trap) begin
      nxt_st.ill_pend = 1'b1;
      nxt_st.istat[IST_ILL] = 1'b1;
    end
    if (trap_req && !nxt_st.trap_pend) begin
      nxt_st.trap_pend = 1'b1;
      nxt_st.trap_num = trap_num;
    end
    if (trap_req) begin
      nxt_st.istat[IST_TRAP] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.istat & nxt_st.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= PIE_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready      = st_ff.pready;
  assign pslverr     = st_ff.pslverr;
  assign prdata      = st_ff.prdata;
  assign exc_valid   = st_ff.valid;
  assign exc_code    = st_ff.code;
  assign exc_handler = st_ff.handler;
  assign irq         = st_ff.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  pie_state_t prev_ff;
  logic       bad_pick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= PIE_ST_RST;
    end else begin
      prev_ff <= st_ff;
    end
  end

  always_comb begin
    bad_pick = 1'b0;
    for (int i = 0; i < MAX_SRC; i++) begin
      if (i < NUM_SRC && prev_ff.pend[i] && !prev_ff.mask[i] &&
          {1'b0, prev_ff.prio[i]} < prev_ff.thresh &&
          (prev_ff.prio[i] < prev_ff.prio[st_ff.src] ||
           (prev_ff.prio[i] == prev_ff.prio[st_ff.src] && 6'(i) < st_ff.src))) begin
        bad_pick = 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_arb_order: assert property (
    $rose(st_ff.valid) && st_ff.kind == K_MASK |-> !bad_pick)
    else $error("Maskable winner not the most urgent");
  a_level_block: assert property (
    $rose(st_ff.valid) && st_ff.kind == K_MASK |->
      {1'b0, prev_ff.prio[st_ff.src]} < prev_ff.thresh)
    else $error("Request at or below threshold forwarded");
  a_mask_block: assert property (
    $rose(st_ff.valid) && st_ff.kind == K_MASK |-> !prev_ff.mask[st_ff.src])
    else $error("Masked source forwarded");
  a_ext_rise: assert property (
    st_ff.ext_cfg[0] == 3'h0 && ext_pin[0] && !st_ff.filt_lvl[0] |=>
      st_ff.pend[EXT_BASE])
    else $error("Rising pin edge not latched");
  a_filt_hold: assert property (
    st_ff.ext_cfg[0][0] && ext_pin[0] != st_ff.filt_lvl[0] &&
    st_ff.filt_cnt[0] == 2'h0 |=> $stable(st_ff.filt_lvl[0]))
    else $error("Filter passed a one-sample glitch");
  a_src_range: assert property (
    st_ff.valid && st_ff.kind == K_MASK |-> int'(st_ff.src) < NUM_SRC)
    else $error("Presented source out of range");
  a_trap_code: assert property (
    $rose(st_ff.valid) && st_ff.kind == K_TRAP |->
      st_ff.code[3:0] == prev_ff.trap_num[3:0] &&
      (prev_ff.trap_num[4] ?
        (st_ff.code[15:4] == 12'h005 && st_ff.handler == VEC_TRAP_HI) :
        (st_ff.code[15:4] == 12'h004 && st_ff.handler == VEC_TRAP_LO)))
    else $error("Trap code or vector wrong");
  a_ill_code: assert property (
    st_ff.valid && st_ff.kind == K_ILL |-> exc_code == 16'h0060 &&
      exc_handler == 32'h00000060)
    else $error("Illegal opcode code or vector wrong");
  a_ill_taken: assert property (
    undefined_opcode_trap && !st_ff.valid |-> ##[1:2] st_ff.valid && st_ff.kind == K_ILL)
    else $error("Illegal opcode not presented");
  a_apb_pulse: assert property (
    pready |=> !pready)
    else $error("Ready stuck high");

  c_ill: cover property (st_ff.valid && st_ff.kind == K_ILL && exc_ack);
  c_trap_hi: cover property (st_ff.valid && st_ff.kind == K_TRAP && exc_code[4]);
  c_mask_ack: cover property (st_ff.valid && st_ff.kind == K_MASK && exc_ack);
  c_irq: cover property ($rose(irq));
endmodule : pie_ctrl

// *** dv/pie_core_model.sv ***
// Purpose: Processor core model that takes presented exceptions
// Assumes: exc_valid holds until the core acknowledges
// Notes:   Ack delay comes from the bench, so slow and prompt cores both occur
`timescale 1ns/10ps
module pie_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        exc_valid,
  input  wire logic [15:0] exc_code,
  input  wire logic [31:0] exc_handler,
  input  wire logic [3:0]  ack_delay,
  output logic             exc_ack,
  output logic [15:0]      seen_code,
  output logic [31:0]      seen_handler,
  output logic [7:0]       seen_count
);
  logic [3:0] wait_ff;
  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  // Ack is a single pulse, raised only while an exception is shown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_ack      <= 1'b0;
      wait_ff      <= 4'h0;
      seen_code    <= 16'h0000;
      seen_handler <= 32'h00000000;
      seen_count   <= 8'h00;
    end else begin
      exc_ack <= 1'b0;
      if (exc_valid && exc_ack) begin
        seen_code    <= exc_code;
        seen_handler <= exc_handler;
        seen_count   <= seen_count + 8'h01;
        wait_ff      <= 4'h0;
      end else if (exc_valid && wait_ff >= ack_delay) begin
        exc_ack <= 1'b1;
      end else if (exc_valid) begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : pie_core_model

// *** dv/prioritized_interrupt_exception_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the vectored request controller
// Assumes: Core model acks each exception after a random delay
// Notes:   Random source pairs plus fixed corner cases
`timescale 1ns/10ps
module prioritized_interrupt_exception_ctrl_tb_top
  import pie_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        trap_req, ill, exc_valid, exc_ack, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, exc_handler, seen_handler, r;
  logic [55:0] src_req, msk;
  logic [6:0]  ext_pin;
  logic [4:0]  trap_num, tn;
  logic [15:0] exc_code, seen_code;
  logic [3:0]  ack_delay;
  logic [7:0]  seen_count;
  logic [2:0]  prio_sh [56];
  logic [4:0]  tbl [4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};
  int          n_fail = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          a, b;

  pie_ctrl #(.NUM_SRC(56)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .src_req(src_req), .ext_pin(ext_pin),
    .trap_req(trap_req), .trap_num(trap_num), .undefined_opcode_trap(ill),
    .exc_valid(exc_valid), .exc_code(exc_code), .exc_handler(exc_handler),
    .exc_ack(exc_ack), .irq(irq));
  pie_core_model u_core (.pclk(pclk), .presetn(presetn), .exc_valid(exc_valid),
    .exc_code(exc_code), .exc_handler(exc_handler), .ack_delay(ack_delay),
    .exc_ack(exc_ack), .seen_code(seen_code), .seen_handler(seen_handler),
    .seen_count(seen_count));
  // ----------------------------------------
  // Clock, timeout, core pacing
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (!exc_valid) ack_delay <= 4'($urandom_range(6, 0));
    if (cycles == 60000) begin
      n_fail++;
      conclude();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, ad, d, x, y);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [11:0] ad, input logic [31:0] exp);
    logic [31:0] x;
    logic        y;
    apb(1'b0, ad, 32'h0, x, y);
    check(nm, x, exp);
    check({nm, "_err"}, {31'h0, y}, 32'h0);
  endtask : rd_chk
  function automatic logic [15:0] mcode(input int s);
    return CODE_MASK + 16'(s * 16);
  endfunction : mcode
  function automatic logic [15:0] tcode(input logic [4:0] n);
    return (n[4] ? CODE_TRAP_HI : CODE_TRAP_LO) | {12'h000, n[3:0]};
  endfunction : tcode
  task automatic wprio(input int s);
    logic [31:0] d;
    d = 32'h0;
    for (int j = 0; j < 8; j++) d[4*j +: 3] = prio_sh[(s/8)*8 + j];
    wr({OFF_PRIO_PG, 5'h00} + 12'(4 * (s/8)), d);
  endtask : wprio
  task automatic wmask();
    wr(OFF_MASK_LO, msk[31:0]);
    wr(OFF_MASK_HI, {8'h00, msk[55:32]});
  endtask : wmask
  task automatic pulse(input logic [55:0] s, input logic t, input logic i, input logic [4:0] n);
    @(posedge pclk);
    src_req  <= s;
    trap_req <= t;
    ill      <= i;
    trap_num <= n;
    @(posedge pclk);
    src_req  <= '0;
    trap_req <= 1'b0;
    ill      <= 1'b0;
  endtask : pulse
  task automatic expect_exc(input logic [15:0] c, input logic [31:0] h);
    logic [7:0] n0;
    n0 = seen_count;
    while (seen_count === n0) @(negedge pclk);
    check("exc_code", {16'h0, seen_code}, {16'h0, c});
    check("exc_handler", seen_handler, h);
  endtask : expect_exc
  task automatic expect_none();
    logic [7:0] n0;
    n0 = seen_count;
    repeat (30) @(negedge pclk);
    check("exc_count", {24'h0, seen_count}, {24'h0, n0});
  endtask : expect_none
  task automatic pair(input int s0, input int s1, input logic [2:0] l0, input logic [2:0] l1);
    int w;
    int l;
    prio_sh[s0] = l0;
    prio_sh[s1] = l1;
    wprio(s0);
    wprio(s1);
    msk[s0] = 1'b0;
    msk[s1] = 1'b0;
    wmask();
    pulse((56'h1 << s0) | (56'h1 << s1), 1'b0, 1'b0, 5'h00);
    w = (l0 < l1 || (l0 == l1 && s0 < s1)) ? s0 : s1;
    l = (w == s0) ? s1 : s0;
    expect_exc(mcode(w), {16'h0, mcode(w)});
    expect_none();
    wr(OFF_THRESH, 32'h8);
    expect_exc(mcode(l), {16'h0, mcode(l)});
    wr(OFF_THRESH, 32'h8);
    msk[s0] = 1'b1;
    msk[s1] = 1'b1;
    wmask();
  endtask : pair
  task automatic pin_step(input logic v, input logic ev);
    logic [7:0] n0;
    n0 = seen_count;
    @(posedge pclk);
    ext_pin <= {6'h00, v};
    repeat (40) @(negedge pclk);
    check("pin_events", {24'h0, seen_count}, {24'h0, n0 + 8'(ev)});
    if (ev) check("pin_code", {16'h0, seen_code}, {16'h0, mcode(1)});
    wr(OFF_THRESH, 32'h8);
  endtask : pin_step
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, trap_req, ill} = '0;
    {paddr, pwdata, src_req, ext_pin, trap_num} = '0;
    void'($urandom(32'h79a5));
    msk = '1;
    for (int i = 0; i < 56; i++) prio_sh[i] = 3'h7;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("mask_hi", OFF_MASK_HI, 32'h00ffffff);
    rd_chk("thresh", OFF_THRESH, 32'h00000008);
    rd_chk("prio_w6", {OFF_PRIO_PG, 5'h00} + 12'h018, 32'h77777777);
    apb(1'b0, 12'h05c, 32'h0, r, e);
    check("unmapped_err", {31'h0, e}, 32'h1);
    check("unmapped_data", r, 32'h0);
    wr(OFF_IMASK, 32'h2);
    pulse('0, 1'b0, 1'b1, 5'h00);
    expect_exc(CODE_ILL, VEC_ILL);
    check("irq_on", {31'h0, irq}, 32'h1);
    rd_chk("istat_ill", OFF_ISTAT, 32'h3);
    repeat (2) @(negedge pclk);
    check("irq_off", {31'h0, irq}, 32'h0);
    wr(OFF_IMASK, 32'h0);
    pulse('0, 1'b1, 1'b1, 5'h13);
    expect_exc(CODE_ILL, VEC_ILL);
    expect_exc(tcode(5'h13), VEC_TRAP_HI);
    check("irq_masked", {31'h0, irq}, 32'h0);
    rd_chk("istat_both", OFF_ISTAT, 32'h7);
    for (int i = 0; i < 8; i++) begin
      tn = (i < 4) ? tbl[i] : 5'($urandom_range(31, 0));
      pulse('0, 1'b1, 1'b0, tn);
      expect_exc(tcode(tn), tn[4] ? VEC_TRAP_HI : VEC_TRAP_LO);
    end
    pair(0, 55, 3'h3, 3'h3);
    pair(55, 2, 3'h1, 3'h6);
    repeat (6) begin
      a = $urandom_range(55, 0);
      b = (a + 1 + $urandom_range(54, 0)) % 56;
      pair(a, b, 3'($urandom_range(7, 0)), 3'($urandom_range(7, 0)));
    end
    // Masked source stays pending, then is held off by the threshold
    prio_sh[9] = 3'h4;
    wprio(9);
    wr(OFF_THRESH, 32'h4);
    pulse(56'h1 << 9, 1'b0, 1'b0, 5'h00);
    expect_none();
    rd_chk("pend_lo", OFF_PEND_LO, 32'h00000200);
    msk[9] = 1'b0;
    wmask();
    expect_none();
    wr(OFF_THRESH, 32'h5);
    expect_exc(mcode(9), {16'h0, mcode(9)});
    msk[9] = 1'b1;
    prio_sh[1] = 3'h0;
    wprio(1);
    msk[1] = 1'b0;
    wmask();
    wr(OFF_THRESH, 32'h8);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_EXT_CFG, 32'(m) << 1);
      pin_step(1'b1, m == 0 || m == 2);
      pin_step(1'b0, m == 1 || m == 2);
    end
    wr(OFF_EXT_CFG, 32'h1);
    @(posedge pclk);
    ext_pin <= 7'h01;
    repeat (2) @(posedge pclk);
    ext_pin <= 7'h00;
    pin_step(1'b0, 1'b0);
    pin_step(1'b1, 1'b1);
    conclude();
  end
endmodule : prioritized_interrupt_exception_ctrl_tb_top
